// ===== sll_regs.vh
// Purpose: Constants for the strap latch and port indicator block
// Assumes: 32-bit APB data, 40 MHz pclk
// Notes: Offsets are byte addresses
`ifndef SLL_REGS_VH
`define SLL_REGS_VH

// Register byte offsets
`define SLL_OFS_CONFIG 12'h000
`define SLL_OFS_LEDCTL 12'h004
`define SLL_OFS_POWER 12'h008
`define SLL_OFS_STATUS 12'h00C

// Chip configuration register fields
`define SLL_CFG_ENDIAN_BIT 10
`define SLL_CFG_EEPROM_BIT 9
`define SLL_CFG_WIDTH_HI 7
`define SLL_CFG_WIDTH_LO 6
`define SLL_WIDTH_16 2'h2
`define SLL_WIDTH_8 2'h1
`define SLL_CFG_RESET 32'h0000_0480

// Indicator control register fields
`define SLL_LED_MODE_HI 9
`define SLL_LED_MODE_LO 8
`define SLL_LED_OVR_HI 14
`define SLL_LED_OVR_LO 12
`define SLL_LED_MAN_ONE 1
`define SLL_LED_MAN_ZERO 0
`define SLL_LEDCTL_RESET 32'h0000_0003

// Indicator modes
`define SLL_MODE_SPEED 2'h0
`define SLL_MODE_ACT 2'h1
`define SLL_MODE_DPX_LA 2'h2
`define SLL_MODE_DPX_LNK 2'h3

// Power register fields
`define SLL_PWR_SOFT_PD_BIT 0
`define SLL_PWR_EVENT_BIT 1
`define SLL_PWR_RESET 32'h0000_0000

// Strap sampling window
`define SLL_CLK_PERIOD_NS 25
`define SLL_STRAP_WIN_NS 1000
`define SLL_STRAP_WIN_CYC ((`SLL_STRAP_WIN_NS + `SLL_CLK_PERIOD_NS - 1) / `SLL_CLK_PERIOD_NS)
`define SLL_CNT_W 6

`endif

// ===== sll_sync.v
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to pclk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module sll_sync #(
   parameter W = 1
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // sll_sync

`default_nettype wire

// ===== sll_top.v
// Purpose: Reset-time strap latching and port indicator drive, APB register access
// Assumes: Link status inputs come from logic on pclk; strap pins are asynchronous
// Notes: Pin output enables are high while the block drives the pin
//
// Operation
// - The two-bit indicator mode selects speed, activity, duplex and link views on both indicators.
// - The unused output pin is driven low at all times.
// - The endianness strap pin is driven low except during the strap sampling window.
// - Endian strap high or open means little-endian, low means big-endian, stored in config bit 10.
// - Bus-width strap high or open means 16-bit, low means 8-bit, stored in config bits 7:6.
// - EEPROM strap high means present, low or open means absent, stored in config bit 9.
// - All straps are sampled and latched together at the end of the reset window.
// - Straps are latched again on leaving hardware power-down, software power-down or reset.
// - Strap pins are pulled inputs during the window and ordinary outputs afterwards.
// - Each indicator is active low, low lights the LED.
// - Automatic indicator behaviour applies only while the override field is zero.
`timescale 1ns/1ps
`default_nettype none
`include "sll_regs.vh"

module sll_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire link_up,
   input wire link_activity,
   input wire link_speed_100,
   input wire link_full_duplex,
   input wire hw_power_down,
   input wire port_indicator_one_in,
   output reg port_indicator_one_out,
   output reg port_indicator_one_oe,
   input wire port_indicator_zero_in,
   output reg port_indicator_zero_out,
   output reg port_indicator_zero_oe,
   input wire endian_strap_in,
   output reg endian_strap_out,
   output reg endian_strap_oe,
   input wire power_event_output_in,
   output reg power_event_output_out,
   output reg power_event_output_oe,
   output reg strap_pulls_on,
   output reg unused_out
);

   localparam [1:0] ST_WIN = 2'b00;
   localparam [1:0] ST_RUN = 2'b01;
   localparam [1:0] ST_PDN = 2'b10;
   localparam integer WIN_LAST_N = `SLL_STRAP_WIN_CYC - 1;
   localparam [`SLL_CNT_W-1:0] WIN_LAST = WIN_LAST_N[`SLL_CNT_W-1:0];

   reg [1:0] state;
   reg [`SLL_CNT_W-1:0] win_cnt;
   reg [31:0] chip_config_reg;
   reg [31:0] led_ctl;
   reg [31:0] power_ctl;
   reg [1:0] next_state;
   reg next_led_one;
   reg next_led_zero;
   wire [4:0] pins_sync;
   wire s_led_one;
   wire s_bus_width;
   wire s_endian;
   wire s_eeprom;
   wire s_hw_pd;
   wire wr_go;
   wire setup;
   wire power_down;
   wire win_done;
   wire [1:0] led_mode;
   wire [2:0] led_ovr;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   sll_sync #(
      .W(5)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({hw_power_down, power_event_output_in, endian_strap_in,
          port_indicator_zero_in, port_indicator_one_in}),
      .q(pins_sync)
   );

   assign s_led_one = pins_sync[0];
   assign s_bus_width = pins_sync[1];
   assign s_endian = pins_sync[2];
   assign s_eeprom = pins_sync[3];
   assign s_hw_pd = pins_sync[4];

   // Decode shared by read and write paths
   function is_mapped;
      input [11:0] a;
      begin
         is_mapped = (a == `SLL_OFS_CONFIG) || (a == `SLL_OFS_LEDCTL) ||
                     (a == `SLL_OFS_POWER) || (a == `SLL_OFS_STATUS);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Strap window sequencing

   assign power_down = s_hw_pd | power_ctl[`SLL_PWR_SOFT_PD_BIT];
   assign win_done = (win_cnt == WIN_LAST);

   always @* begin
      next_state = state;
      case (state)
         ST_WIN: begin
            if (win_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (power_down) begin
               next_state = ST_PDN;
            end
         end
         ST_PDN: begin
            // Leaving power-down reopens the window to latch again
            if (!power_down) begin
               next_state = ST_WIN;
            end
         end
         default: begin
            next_state = ST_WIN;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_WIN;
         win_cnt <= {`SLL_CNT_W{1'b0}};
      end else begin
         state <= next_state;
         if (state == ST_WIN && !win_done) begin
            win_cnt <= win_cnt + 1'b1;
         end else begin
            win_cnt <= {`SLL_CNT_W{1'b0}};
         end
      end
   end

   // The window is far longer than the synchroniser delay, so the sampled
   // levels have settled on the pull values before the latch edge.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chip_config_reg <= `SLL_CFG_RESET;
      end else if (state == ST_WIN && win_done) begin
         chip_config_reg[`SLL_CFG_ENDIAN_BIT] <= s_endian;
         chip_config_reg[`SLL_CFG_EEPROM_BIT] <= s_eeprom;
         chip_config_reg[`SLL_CFG_WIDTH_HI:`SLL_CFG_WIDTH_LO] <=
            s_bus_width ? `SLL_WIDTH_16 : `SLL_WIDTH_8;
      end
      // Otherwise held whatever the pins do later
   end

   ////////////////////////////////////////////////////////////////////////////
   // Indicator selection

   assign led_mode = led_ctl[`SLL_LED_MODE_HI:`SLL_LED_MODE_LO];
   assign led_ovr = led_ctl[`SLL_LED_OVR_HI:`SLL_LED_OVR_LO];

   // Values are "lit" here; the pins take the inverse
   always @* begin
      next_led_one = 1'b0;
      next_led_zero = 1'b0;
      if (led_ovr != 3'h0) begin
         // Manual bits are already "lit" values; the pin stage inverts once
         next_led_one = led_ctl[`SLL_LED_MAN_ONE];
         next_led_zero = led_ctl[`SLL_LED_MAN_ZERO];
      end else begin
         case (led_mode)
            `SLL_MODE_SPEED: begin
               next_led_one = link_speed_100;
               next_led_zero = link_up & ~link_activity;
            end
            `SLL_MODE_ACT: begin
               next_led_one = link_activity;
               next_led_zero = link_up;
            end
            `SLL_MODE_DPX_LA: begin
               next_led_one = link_full_duplex;
               next_led_zero = link_up & ~link_activity;
            end
            `SLL_MODE_DPX_LNK: begin
               next_led_one = link_full_duplex;
               next_led_zero = link_up;
            end
            default: begin
               next_led_one = 1'b0;
               next_led_zero = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_indicator_one_out <= 1'b1;
         port_indicator_one_oe <= 1'b0;
         port_indicator_zero_out <= 1'b1;
         port_indicator_zero_oe <= 1'b0;
         endian_strap_out <= 1'b0;
         endian_strap_oe <= 1'b0;
         power_event_output_out <= 1'b0;
         power_event_output_oe <= 1'b0;
         strap_pulls_on <= 1'b1;
         unused_out <= 1'b0;
      end else begin
         unused_out <= 1'b0;
         port_indicator_one_out <= ~next_led_one;
         port_indicator_zero_out <= ~next_led_zero;
         endian_strap_out <= 1'b0;
         power_event_output_out <= power_ctl[`SLL_PWR_EVENT_BIT];
         // Pins turn to inputs on the same edge that the window opens, as the enables are registered from next_state
         strap_pulls_on <= (next_state == ST_WIN);
         port_indicator_one_oe <= (next_state != ST_WIN);
         port_indicator_zero_oe <= (next_state != ST_WIN);
         endian_strap_oe <= (next_state != ST_WIN);
         power_event_output_oe <= (next_state != ST_WIN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states

   assign setup = psel & ~penable;
   assign wr_go = psel & penable & pready & pwrite;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~is_mapped(paddr);
         prdata <= 32'h0000_0000;
         if (setup && !pwrite) begin
            case (paddr)
               `SLL_OFS_CONFIG: prdata <= chip_config_reg;
               `SLL_OFS_LEDCTL: prdata <= led_ctl;
               `SLL_OFS_POWER: prdata <= power_ctl;
               `SLL_OFS_STATUS: prdata <= {25'h000_0000, s_led_one, state,
                                           link_full_duplex, link_speed_100,
                                           link_activity, link_up};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Only the documented fields are writable; other bits stay zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_ctl <= `SLL_LEDCTL_RESET;
         power_ctl <= `SLL_PWR_RESET;
      end else if (wr_go) begin
         if (paddr == `SLL_OFS_LEDCTL) begin
            led_ctl <= pwdata & 32'h0000_7303;
         end
         if (paddr == `SLL_OFS_POWER) begin
            power_ctl <= pwdata & 32'h0000_0003;
         end
      end
   end

endmodule // sll_top

`default_nettype wire

// ===== sll_sva.sv
// Purpose: Port-level checks for strap window and pin drive
// Assumes: Bound into sll_top
// Notes: Window length is measured by a helper counter
`timescale 1ns/1ps
`default_nettype none
`include "sll_regs.vh"
module sll_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic endian_strap_out,
   input wire logic endian_strap_oe,
   input wire logic port_indicator_one_oe,
   input wire logic port_indicator_zero_oe,
   input wire logic power_event_output_oe,
   input wire logic strap_pulls_on,
   input wire logic unused_out
);
   logic [7:0] win_cnt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         win_cnt <= 8'h00;
      else if (strap_pulls_on)
         win_cnt <= win_cnt + 8'h01;
      else
         win_cnt <= 8'h00;
   end
   unused_low_a: assert property (!unused_out)
      else $error("unused pin not low");
   endian_low_a: assert property (endian_strap_oe |-> !endian_strap_out)
      else $error("endian pin driven high");
   pulls_input_a: assert property (strap_pulls_on |-> !(endian_strap_oe ||
      port_indicator_one_oe || port_indicator_zero_oe || power_event_output_oe))
      else $error("pin driven during window");
   release_all_a: assert property ($fell(strap_pulls_on) |-> endian_strap_oe &&
      port_indicator_one_oe && port_indicator_zero_oe && power_event_output_oe)
      else $error("pins not released together");
   // Exit from power-down starts the pulls on the same edge as the window, as after reset
   window_len_a: assert property ($fell(strap_pulls_on) |->
      win_cnt inside {[`SLL_STRAP_WIN_CYC - 2:`SLL_STRAP_WIN_CYC]})
      else $error("window length wrong");
   oe_follow_a: assert property ($changed(endian_strap_oe) |-> $changed(strap_pulls_on))
      else $error("pin drive changed outside window edge");
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   cover property ($fell(strap_pulls_on));
   cover property ($rose(strap_pulls_on));
   cover property (pslverr);
endmodule // sll_sva
bind sll_top sll_sva sva_u (.*);
`default_nettype wire

// ===== sll_board.sv
// Purpose: Board pulls behind the strap-capable pins
// Assumes: Every strap pin has a board pull
// Notes: A released pin shows its pull level, never the last driven value
`timescale 1ns/1ps
`default_nettype none
module sll_board (
   input wire logic bw_strap,
   input wire logic endian_set,
   input wire logic eeprom_set,
   input wire logic port_indicator_one_out,
   input wire logic port_indicator_one_oe,
   input wire logic port_indicator_zero_out,
   input wire logic port_indicator_zero_oe,
   input wire logic endian_strap_out,
   input wire logic endian_strap_oe,
   input wire logic power_event_output_out,
   input wire logic power_event_output_oe,
   output logic port_indicator_one_in,
   output logic port_indicator_zero_in,
   output logic endian_strap_in,
   output logic power_event_output_in
);
   // Indicator one stays pulled high, the reserved low setting is never fitted
   assign port_indicator_one_in = port_indicator_one_oe ? port_indicator_one_out : 1'b1;
   assign port_indicator_zero_in = port_indicator_zero_oe ? port_indicator_zero_out : bw_strap;
   assign endian_strap_in = endian_strap_oe ? endian_strap_out : endian_set;
   assign power_event_output_in = power_event_output_oe ? power_event_output_out : eeprom_set;
endmodule // sll_board
`default_nettype wire

// ===== tb_strap_latch_and_link_led.sv
// Purpose: Self-checking bench for strap latching and indicator drive
// Assumes: Reset hold shortened to 16 cycles
// Notes: A cycle ceiling ends a hang
`timescale 1ns/1ps
`default_nettype none
`include "sll_regs.vh"
module tb_strap_latch_and_link_led;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hw_power_down = 0;
   logic link_up = 0, link_activity = 0, link_speed_100 = 0, link_full_duplex = 0;
   logic bw_strap = 1, endian_set = 1, eeprom_set = 0, err, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic strap_pulls_on, unused_out, endian_strap_in, endian_strap_out, endian_strap_oe;
   logic port_indicator_one_in, port_indicator_one_out, port_indicator_one_oe;
   logic port_indicator_zero_in, port_indicator_zero_out, port_indicator_zero_oe;
   logic power_event_output_in, power_event_output_out, power_event_output_oe;
   int mismatches = 0, cmp_count = 0, cycles = 0;
   sll_top dut_u (.*);
   sll_board board_u (.*);
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end
   ////////////////////////////////////////
   task automatic chk(string name, logic [31:0] got, logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Ready and data are taken at the rising edge that ends the access phase
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      int n;
      logic rdy;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         rdy = pready;
      end while (rdy !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", rdy, 1'b1);
   endtask
   task automatic wait_window(logic rise);
      int n;
      n = 0;
      while (rise && strap_pulls_on !== 1'b1 && n < 100) begin
         @(negedge pclk);
         n++;
      end
      while (strap_pulls_on !== 1'b0 && n < 200) begin
         @(negedge pclk);
         n++;
      end
      chk("window end", n < 200, 1'b1);
   endtask
   function automatic logic [31:0] exp_cfg(logic w, logic e, logic p);
      return {21'h0, e, p, 1'h0, w ? `SLL_WIDTH_16 : `SLL_WIDTH_8, 6'h0};
   endfunction
   ////////////////////////////////////////
   task automatic t_straps();
      for (int i = 0; i < 8; i++) begin
         @(posedge pclk);
         presetn <= 1'b0;
         bw_strap <= i[0];
         endian_set <= i[1];
         eeprom_set <= i[2];
         repeat (16) @(posedge pclk);
         presetn <= 1'b1;
         wait_window(1'b0);
         apb(1'b0, `SLL_OFS_CONFIG, 32'h0);
         chk("config", rd, exp_cfg(i[0], i[1], i[2]));
      end
      chk("endian pin", endian_strap_out, 1'b0);
   endtask
   task automatic t_hold();
      bw_strap <= 1'b0;
      endian_set <= 1'b0;
      apb(1'b1, `SLL_OFS_CONFIG, 32'h0);
      apb(1'b0, `SLL_OFS_CONFIG, 32'h0);
      chk("config hold", rd, exp_cfg(1'b1, 1'b1, 1'b1));
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped err", err, 1'b1);
      chk("unmapped data", rd, 32'h0);
      apb(1'b0, `SLL_OFS_STATUS, 32'h0);
      chk("status", rd, 32'h0000_0050);
   endtask
   task automatic t_pd();
      hw_power_down <= 1'b1;
      repeat (8) @(posedge pclk);
      hw_power_down <= 1'b0;
      wait_window(1'b1);
      apb(1'b0, `SLL_OFS_CONFIG, 32'h0);
      chk("config after hw down", rd, exp_cfg(1'b0, 1'b0, 1'b1));
      bw_strap <= 1'b1;
      eeprom_set <= 1'b0;
      apb(1'b1, `SLL_OFS_POWER, 32'h0000_0001);
      apb(1'b1, `SLL_OFS_POWER, 32'h0);
      wait_window(1'b1);
      apb(1'b0, `SLL_OFS_CONFIG, 32'h0);
      chk("config after soft down", rd, exp_cfg(1'b1, 1'b0, 1'b0));
      apb(1'b1, `SLL_OFS_POWER, 32'h0000_0002);
      @(posedge pclk);
      @(negedge pclk);
      chk("event pin", power_event_output_out, 1'b1);
      apb(1'b0, `SLL_OFS_POWER, 32'h0);
      chk("power readback", rd, 32'h0000_0002);
   endtask
   task automatic t_modes();
      logic [1:0] md;
      logic one_lit, zero_lit;
      apb(1'b0, `SLL_OFS_LEDCTL, 32'h0);
      chk("ledctl reset", rd, `SLL_LEDCTL_RESET);
      for (int m = 0; m < 16; m++) begin
         md = m[3:2];
         link_up <= |m[1:0];
         link_activity <= m[0];
         link_speed_100 <= m[1];
         link_full_duplex <= m[0] ^ m[1];
         apb(1'b1, `SLL_OFS_LEDCTL, {22'h0, md, 8'h0});
         repeat (2) @(posedge pclk);
         @(negedge pclk);
         one_lit = (md == 2'h0) ? m[1] : (md == 2'h1) ? m[0] : m[0] ^ m[1];
         zero_lit = |m[1:0] && (md[0] || !m[0]);
         chk("indicator one", port_indicator_one_out, !one_lit);
         chk("indicator zero", port_indicator_zero_out, !zero_lit);
      end
      apb(1'b1, `SLL_OFS_LEDCTL, 32'h0000_1002);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("override one", port_indicator_one_out, 1'b0);
      chk("override zero", port_indicator_zero_out, 1'b1);
   endtask
   initial begin
      t_straps();
      t_hold();
      t_pd();
      t_modes();
      stop_test();
   end
endmodule // tb_strap_latch_and_link_led
`default_nettype wire
